// file: core/fep_flash_ctrl.sv
/*
 * Flash module control shared by two CPUs: single-bit ECC error counting
 * and interrupts, bank and charge pump fall-back power, pump semaphore and
 * the two-CPU pump power-down interlock, all behind one APB slave.
 * Assumes the flash access strobes come from logic on clk.
 */
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "fep_defs.svh"

module fep_flash_ctrl
    import fep_pkg::*;
#(
    parameter int CNT_W  = 16,
    parameter int ADDR_W = 20
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [1:0]        accValid,
    input  wire logic [1:0]        accFetch,
    input  wire logic [ADDR_W-1:0] accAddr0,
    input  wire logic [ADDR_W-1:0] accAddr1,
    input  wire logic [1:0]        sbeDetect,
    output logic      [1:0]        bankPowerMode0,
    output logic      [1:0]        bankPowerMode1,
    output logic                   pumpLowPower,
    output logic                   pumpReady,
    output logic      [1:0]        sbeIrq,
    output logic                   irq
);

    // ==========================================================
    // Elaboration checks
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
        $error("CNT_W must lie in 2..32");
    end
    if (ADDR_W < 1 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie in 1..32");
    end

    // ==========================================================
    // State
    logic [1:0]        bankMode [2];
    logic [1:0]        pumpMode;
    fep_sem_t          semOwner;
    logic [CNT_W-1:0]  thresh;
    logic [CNT_W-1:0]  errCount [2];
    logic [1:0]        pdReq;
    logic [1:0]        dataErrSeen;
    logic [ADDR_W-1:0] lastDataAddr [2];
    logic [1:0]        intStat;
    logic [1:0]        intEn;
    logic              pumpSleep;

    logic [1:0]        next_bankMode [2];
    logic [1:0]        next_pumpMode;
    fep_sem_t          next_semOwner;
    logic [CNT_W-1:0]  next_thresh;
    logic [CNT_W-1:0]  next_errCount [2];
    logic [1:0]        next_pdReq;
    logic [1:0]        next_dataErrSeen;
    logic [ADDR_W-1:0] next_lastDataAddr [2];
    logic [1:0]        next_intStat;
    logic [1:0]        next_intEn;
    logic              next_pumpSleep;
    logic [31:0]       next_prdata;
    logic              next_pslverr;

    logic              wrEn;
    logic              setup;
    logic [ADDR_W-1:0] addrOf [2];
    logic [1:0]        errEvt;
    logic [1:0]        raise;
    logic [1:0]        pumpWrSleep;
    logic [1:0]        intClr;

    assign addrOf[0] = accAddr0;
    assign addrOf[1] = accAddr1;
    assign wrEn      = psel & penable & pwrite;
    assign setup     = psel & ~penable;
    // Zero wait states: read data is staged during setup
    assign pready    = 1'b1;

    // ==========================================================
    // Address decode for the error answer; write strobes compare paddr directly
    function automatic logic isMapped(input logic [11:0] a);
        unique case (a)
            `FEP_OFS_BANK_FB0, `FEP_OFS_PUMP_CTRL0, `FEP_OFS_BANK_FB1,
            `FEP_OFS_PUMP_CTRL1, `FEP_OFS_PUMP_SEM, `FEP_OFS_ERR_THRESH,
            `FEP_OFS_ERR_COUNT0, `FEP_OFS_ERR_COUNT1, `FEP_OFS_PUMP_STAT,
            `FEP_OFS_INT_STAT, `FEP_OFS_INT_EN, `FEP_OFS_INT_CLR: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction : isMapped

    function automatic logic wrHit(input logic [11:0] ofs);
        return wrEn && (paddr == ofs);
    endfunction : wrHit

    // ==========================================================
    // Error detection and counting
    always_comb begin
        next_dataErrSeen  = dataErrSeen;
        next_lastDataAddr = lastDataAddr;
        next_errCount     = errCount;
        errEvt            = 2'h0;
        raise             = 2'h0;
        for (int i = 0; i < 2; i++) begin
            errEvt[i] = accValid[i] & sbeDetect[i] & (accFetch[i] |
                        ~(dataErrSeen[i] & (addrOf[i] == lastDataAddr[i])));
            if (accValid[i] & sbeDetect[i] & ~accFetch[i]) begin
                next_dataErrSeen[i]  = 1'b1;
                next_lastDataAddr[i] = addrOf[i];
            end
            if (errEvt[i]) begin
                if ((CNT_W+1)'(errCount[i]) + (CNT_W+1)'(1) > (CNT_W+1)'(thresh)) begin
                    raise[i]         = 1'b1;
                    next_errCount[i] = '0;
                end else begin
                    next_errCount[i] = errCount[i] + CNT_W'(1);
                end
            end
        end
    end

    // ==========================================================
    // Interrupt status, enable and clear
    always_comb begin
        intClr       = wrHit(`FEP_OFS_INT_CLR) ? pwdata[1:0] : 2'h0;
        next_intEn   = wrHit(`FEP_OFS_INT_EN) ? pwdata[1:0] : intEn;
        // bit of the accessing CPU; set beats clear
        next_intStat = (intStat & ~intClr) | raise;
    end

    // ==========================================================
    // Fall-back power fields and semaphore
    always_comb begin
        next_bankMode = bankMode;
        next_pumpMode = pumpMode;
        next_semOwner = semOwner;
        next_thresh   = thresh;
        pumpWrSleep   = 2'h0;
        // bank field zero sleeps that bank
        // forced bank low power by software
        if (wrHit(`FEP_OFS_BANK_FB0)) begin
            next_bankMode[0] = pwdata[`FEP_BANK_W-1:0];
        end
        if (wrHit(`FEP_OFS_BANK_FB1)) begin
            next_bankMode[1] = pwdata[`FEP_BANK_W-1:0];
        end
        if (wrHit(`FEP_OFS_PUMP_CTRL0)) begin
            next_pumpMode[0] = pwdata[`FEP_PUMP_BIT];
            pumpWrSleep[0]   = (pwdata[`FEP_PUMP_BIT] == `FEP_PUMP_SLEEP);
        end
        if (wrHit(`FEP_OFS_PUMP_CTRL1) && semOwner == FEP_SEM_CPU1) begin
            next_pumpMode[1] = pwdata[`FEP_PUMP_BIT];
            pumpWrSleep[1]   = (pwdata[`FEP_PUMP_BIT] == `FEP_PUMP_SLEEP);
        end
        // Claim only when free; release by writing free
        if (wrHit(`FEP_OFS_PUMP_SEM)) begin
            if (pwdata[1:0] == 2'(FEP_SEM_FREE)) begin
                next_semOwner = FEP_SEM_FREE;
            end else if (semOwner == FEP_SEM_FREE && pwdata[1:0] != 2'h3) begin
                next_semOwner = fep_sem_t'(pwdata[1:0]);
            end
        end
        if (wrHit(`FEP_OFS_ERR_THRESH)) begin
            next_thresh = pwdata[CNT_W-1:0];
        end
    end

    // ==========================================================
    // Pump power-down interlock
    always_comb begin
        next_pdReq = pdReq;
        // any flash access cancels pending requests
        if (|accValid) begin
            next_pdReq = 2'h0;
        end
        // A request made in the same cycle as an access still stands
        next_pdReq = next_pdReq | pumpWrSleep;
        next_pumpSleep = (&next_pdReq) &&
                         (next_pumpMode == {`FEP_PUMP_SLEEP, `FEP_PUMP_SLEEP});
    end

    // ==========================================================
    // APB read path, staged in setup so prdata comes from a flop
    always_comb begin
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (setup) begin
            next_prdata  = 32'h0000_0000;
            next_pslverr = ~isMapped(paddr);
            unique case (paddr)
                `FEP_OFS_BANK_FB0:   next_prdata[1:0] = bankMode[0];
                `FEP_OFS_BANK_FB1:   next_prdata[1:0] = bankMode[1];
                `FEP_OFS_PUMP_CTRL0: next_prdata[0]   = pumpMode[0];
                `FEP_OFS_PUMP_CTRL1: next_prdata[0]   = pumpMode[1];
                `FEP_OFS_PUMP_SEM:   next_prdata[1:0] = semOwner;
                `FEP_OFS_ERR_THRESH: next_prdata[CNT_W-1:0] = thresh;
                `FEP_OFS_ERR_COUNT0: next_prdata[CNT_W-1:0] = errCount[0];
                `FEP_OFS_ERR_COUNT1: next_prdata[CNT_W-1:0] = errCount[1];
                `FEP_OFS_PUMP_STAT: begin
                    next_prdata[`FEP_STAT_READY]  = ~pumpSleep;
                    next_prdata[`FEP_STAT_LOWPWR] = pumpSleep;
                    next_prdata[`FEP_STAT_REQ0]   = pdReq[0];
                    next_prdata[`FEP_STAT_REQ1]   = pdReq[1];
                end
                `FEP_OFS_INT_STAT:   next_prdata[1:0] = intStat;
                `FEP_OFS_INT_EN:     next_prdata[1:0] = intEn;
                default:             next_prdata      = 32'h0000_0000;
            endcase
        end else if (psel & penable) begin
            next_pslverr = pslverr;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bankMode[0]     <= `FEP_BANK_RST;
            bankMode[1]     <= `FEP_BANK_RST;
            pumpMode        <= {`FEP_PUMP_RST, `FEP_PUMP_RST};
            semOwner        <= FEP_SEM_FREE;
            thresh          <= CNT_W'(`FEP_THRESH_RST);
            errCount[0]     <= '0;
            errCount[1]     <= '0;
            pdReq           <= 2'h0;
            dataErrSeen     <= 2'h0;
            lastDataAddr[0] <= '0;
            lastDataAddr[1] <= '0;
            intStat         <= 2'h0;
            intEn           <= 2'h0;
            pumpSleep       <= 1'b0;
            prdata          <= 32'h0000_0000;
            pslverr         <= 1'b0;
        end else begin
            bankMode        <= next_bankMode;
            pumpMode        <= next_pumpMode;
            semOwner        <= next_semOwner;
            thresh          <= next_thresh;
            errCount        <= next_errCount;
            pdReq           <= next_pdReq;
            dataErrSeen     <= next_dataErrSeen;
            lastDataAddr    <= next_lastDataAddr;
            intStat         <= next_intStat;
            intEn           <= next_intEn;
            pumpSleep       <= next_pumpSleep;
            prdata          <= next_prdata;
            pslverr         <= next_pslverr;
        end
    end

    // ==========================================================
    // Outputs
    assign bankPowerMode0 = bankMode[0];
    assign bankPowerMode1 = bankMode[1];
    assign pumpLowPower   = pumpSleep;
    assign pumpReady      = ~pumpSleep;
    assign sbeIrq         = intStat & intEn;
    assign irq            = |(intStat & intEn);

endmodule : fep_flash_ctrl

// file: core/fep_defs.svh
/*
 * Register map, field layout and reset values of the flash ECC and pump
 * power control block. Assumes a 32-bit APB slave with word offsets.
 */
// Contract
// - A single-bit ECC error interrupts the CPU that made the access.
// - Threshold zero makes every single-bit error interrupt, refetch included; a data reread of the last data error address does not.
// - The error threshold field resets to zero.
// - Repeated interrupts for one error arise only from instruction fetches.
// - One CPU cannot cut pump power while the other uses flash.
// - Pump sleeps only after both CPUs request it with no access between.
// - Bank fall-back field written zero puts that bank to sleep.
// - Pump fall-back field written zero selects pump sleep.
// - Software may force the flash bank low-power through fall-back fields.
`ifndef FEP_DEFS_SVH
`define FEP_DEFS_SVH

// ==========================================================
// Register offsets
`define FEP_OFS_BANK_FB0   12'h000
`define FEP_OFS_PUMP_CTRL0 12'h004
`define FEP_OFS_BANK_FB1   12'h008
`define FEP_OFS_PUMP_CTRL1 12'h00C
`define FEP_OFS_PUMP_SEM   12'h010
`define FEP_OFS_ERR_THRESH 12'h014
`define FEP_OFS_ERR_COUNT0 12'h018
`define FEP_OFS_ERR_COUNT1 12'h01C
`define FEP_OFS_PUMP_STAT  12'h020
`define FEP_OFS_INT_STAT   12'h024
`define FEP_OFS_INT_EN     12'h028
`define FEP_OFS_INT_CLR    12'h02C

// ==========================================================
// Field positions and reset values
`define FEP_BANK_W         2
`define FEP_BANK_RST       2'h3
`define FEP_BANK_SLEEP     2'h0
`define FEP_PUMP_BIT       0
`define FEP_PUMP_RST       1'h1
`define FEP_PUMP_SLEEP     1'h0
`define FEP_THRESH_RST     32'h0000_0000
`define FEP_STAT_READY     0
`define FEP_STAT_LOWPWR    1
`define FEP_STAT_REQ0      2
`define FEP_STAT_REQ1      3

`endif

// file: core/fep_pkg.sv
/*
 * Types for the flash ECC and pump power control block.
 * Assumes fep_defs.svh for all numeric constants.
 */
package fep_pkg;

    // Pump semaphore owner
    typedef enum logic [1:0] {
        FEP_SEM_FREE,
        FEP_SEM_CPU0,
        FEP_SEM_CPU1
    } fep_sem_t;

endpackage : fep_pkg

// file: test/fep_flash_ctrl_sva.sv
/*
 * Port-level checks of the flash ECC and pump power block.
 * Assumes binding onto fep_flash_ctrl with one clock and reset.
 */
`timescale 1ns/10ps
`include "fep_defs.svh"
module fep_flash_ctrl_sva
    import fep_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [1:0]  accValid,
    input wire logic [1:0]  sbeDetect,
    input wire logic [1:0]  bankPowerMode0,
    input wire logic        pumpLowPower,
    input wire logic        pumpReady,
    input wire logic [1:0]  sbeIrq,
    input wire logic        irq
);
    // ====================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic wrEdge;
    assign wrEdge = psel && penable && pwrite && pready;
    a_irq_or: assert property (irq == (|sbeIrq))
        else $error("irq is not the OR of sources");
    // Status may sit one flop behind the event
    a_irq_cause: assert property ($rose(sbeIrq[0]) |->
        $past(accValid[0] && sbeDetect[0]) || $past(accValid[0] && sbeDetect[0], 2)
        || $past(wrEdge) || $past(wrEdge, 2))
        else $error("interrupt rose without an error event");
    a_irq_sticky: assert property (sbeIrq[1] && !wrEdge && !$past(wrEdge) |=> sbeIrq[1])
        else $error("interrupt dropped without a write");
    // Clear with no new event in the same cycle must drop the source
    a_irq_clear: assert property (wrEdge && paddr == `FEP_OFS_INT_CLR && pwdata[1]
        && !(accValid[1] && sbeDetect[1]) |=> !sbeIrq[1])
        else $error("interrupt not cleared by write");
    a_pump_wake: assert property ((|accValid) |=> !pumpLowPower)
        else $error("pump stayed low power after access");
    a_pump_entry: assert property ($rose(pumpLowPower) |-> $past(wrEdge) || $past(wrEdge, 2))
        else $error("pump entered low power without a request");
    a_lowpwr_stay: assert property (pumpLowPower && !(|accValid) && !wrEdge
        && !$past(wrEdge) |=> pumpLowPower)
        else $error("pump woke without cause");
    a_ready_inv: assert property (pumpReady != pumpLowPower)
        else $error("pump ready does not show power mode");
    a_bank_write: assert property (!$stable(bankPowerMode0) |-> $past(wrEdge))
        else $error("bank mode changed without a write");
    c_pump_low: cover property ($rose(pumpLowPower));
    c_irq_rise: cover property ($rose(sbeIrq[1]));
    c_bus_err: cover property (pslverr);
endmodule : fep_flash_ctrl_sva

bind fep_flash_ctrl fep_flash_ctrl_sva chk_u (.clk, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .accValid, .sbeDetect, .bankPowerMode0,
    .pumpLowPower, .pumpReady, .sbeIrq, .irq);

// file: test/fep_cpu_model.sv
/*
 * Flash-side access strobes of the two CPUs.
 * Assumes the bench calls access() to issue one flash read.
 */
`timescale 1ns/10ps
module fep_cpu_model
    import fep_pkg::*;
#(
    parameter int ADDR_W = 20
) (
    input  wire logic              clk,
    output logic      [1:0]        accValid,
    output logic      [1:0]        accFetch,
    output logic      [ADDR_W-1:0] accAddr0,
    output logic      [ADDR_W-1:0] accAddr1,
    output logic      [1:0]        sbeDetect
);
    initial begin
        accValid = 2'h0;
        accFetch = 2'h0;
        sbeDetect = 2'h0;
        accAddr0 = '0;
        accAddr1 = '0;
    end
    // ====================
    // accesses only on request
    // Released lines flip so stale values never look valid
    task automatic access(input int cpu, input logic fetch, input logic err,
                          input logic [ADDR_W-1:0] addr);
        @(posedge clk);
        accValid[cpu] <= 1'b1;
        accFetch[cpu] <= fetch;
        sbeDetect[cpu] <= err;
        if (cpu == 0) accAddr0 <= addr;
        else accAddr1 <= addr;
        @(posedge clk);
        accValid[cpu] <= 1'b0;
        accFetch[cpu] <= ~fetch;
        sbeDetect[cpu] <= ~err;
        if (cpu == 0) accAddr0 <= ~addr;
        else accAddr1 <= ~addr;
    endtask : access
endmodule : fep_cpu_model

// file: test/fep_flash_ctrl_tb_top.sv
/*
 * Self-checking bench: APB register sequences plus CPU flash accesses.
 * Assumes fep_cpu_model drives the flash strobes.
 */
`timescale 1ns/10ps
`include "fep_defs.svh"
module fep_flash_ctrl_tb_top
    import fep_pkg::*;
;
    logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic        pumpLowPower, pumpReady, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [1:0]  accValid, accFetch, sbeDetect, bankPowerMode0, bankPowerMode1, sbeIrq;
    logic [19:0] accAddr0, accAddr1;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;

    fep_flash_ctrl #(.CNT_W(16), .ADDR_W(20)) dut_u (.clk, .arst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .accValid, .accFetch,
        .accAddr0, .accAddr1, .sbeDetect, .bankPowerMode0, .bankPowerMode1,
        .pumpLowPower, .pumpReady, .sbeIrq, .irq);
    fep_cpu_model #(.ADDR_W(20)) cpu_u (.clk, .accValid, .accFetch, .accAddr0,
        .accAddr1, .sbeDetect);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ====================
    // Tasks
    task automatic stop_test;
        $display("Checks %0d, errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // Leading edge keeps release and next setup apart
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rdc

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            $display("[FAIL] %0t: timeout", $time);
            stop_test;
        end
    end

    // ====================
    // Sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, arst_n} = '0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rdc(`FEP_OFS_ERR_THRESH, 32'h0);
        rdc(`FEP_OFS_BANK_FB0, 32'h3);
        rdc(`FEP_OFS_PUMP_STAT, 32'h1);
        xfer(1'b0, 12'h100, 32'h0);
        chk(rerr, 1'b1);
        xfer(1'b1, `FEP_OFS_INT_EN, 32'h3);
        // Same fetch error raised on every refetch
        repeat (2) begin
            cpu_u.access(1, 1'b1, 1'b1, 20'hABCDE);
            tick;
            chk(sbeIrq, 2'h2);
            chk(irq, 1'b1);
            xfer(1'b1, `FEP_OFS_INT_CLR, 32'h2);
            tick;
            chk(irq, 1'b0);
        end
        cpu_u.access(0, 1'b0, 1'b1, 20'h00123);
        tick;
        chk(sbeIrq, 2'h1);
        xfer(1'b1, `FEP_OFS_INT_CLR, 32'h1);
        cpu_u.access(0, 1'b0, 1'b1, 20'h00123);
        tick;
        chk(irq, 1'b0);
        xfer(1'b1, `FEP_OFS_INT_EN, 32'h2);
        cpu_u.access(0, 1'b0, 1'b1, 20'h00456);
        tick;
        chk(sbeIrq, 2'h0);
        rdc(`FEP_OFS_INT_STAT, 32'h1);
        xfer(1'b1, `FEP_OFS_INT_CLR, 32'h1);
        xfer(1'b1, `FEP_OFS_INT_EN, 32'h3);
        xfer(1'b1, `FEP_OFS_ERR_THRESH, 32'h1);
        cpu_u.access(0, 1'b1, 1'b1, 20'h00789);
        tick;
        chk(irq, 1'b0);
        rdc(`FEP_OFS_ERR_COUNT0, 32'h1);
        cpu_u.access(0, 1'b1, 1'b1, 20'h00789);
        tick;
        chk(sbeIrq, 2'h1);
        rdc(`FEP_OFS_ERR_COUNT0, 32'h0);
        // Forced power-down, first CPU then second
        xfer(1'b1, `FEP_OFS_BANK_FB0, 32'h0);
        xfer(1'b1, `FEP_OFS_PUMP_CTRL0, 32'h0);
        tick;
        chk(bankPowerMode0, 2'h0);
        chk(pumpLowPower, 1'b0);
        xfer(1'b1, `FEP_OFS_PUMP_CTRL1, 32'h0);
        tick;
        chk(pumpLowPower, 1'b0);
        xfer(1'b1, `FEP_OFS_PUMP_SEM, 32'h2);
        rdc(`FEP_OFS_PUMP_SEM, 32'h2);
        xfer(1'b1, `FEP_OFS_BANK_FB1, 32'h0);
        xfer(1'b1, `FEP_OFS_PUMP_CTRL1, 32'h0);
        xfer(1'b1, `FEP_OFS_PUMP_SEM, 32'h0);
        tick;
        chk(bankPowerMode1, 2'h0);
        chk(pumpLowPower, 1'b1);
        chk(pumpReady, 1'b0);
        xfer(1'b0, `FEP_OFS_PUMP_STAT, 32'h0);
        chk(rdat[1:0], 2'h2);
        cpu_u.access(1, 1'b0, 1'b0, 20'h00001);
        tick;
        chk(pumpLowPower, 1'b0);
        // Access between the two requests keeps the pump up
        xfer(1'b1, `FEP_OFS_PUMP_CTRL0, 32'h0);
        cpu_u.access(0, 1'b1, 1'b0, 20'h00002);
        xfer(1'b1, `FEP_OFS_PUMP_SEM, 32'h2);
        xfer(1'b1, `FEP_OFS_PUMP_CTRL1, 32'h0);
        xfer(1'b1, `FEP_OFS_PUMP_SEM, 32'h0);
        tick;
        chk(pumpLowPower, 1'b0);
        xfer(1'b1, `FEP_OFS_PUMP_CTRL0, 32'h0);
        tick;
        chk(pumpLowPower, 1'b1);
        // Mid-run reset restores the power-up values; two edges keep $past clean
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rdc(`FEP_OFS_ERR_THRESH, 32'h0);
        rdc(`FEP_OFS_PUMP_STAT, 32'h1);
        chk(irq, 1'b0);
        stop_test;
    end
endmodule : fep_flash_ctrl_tb_top
